/* src/gpde_defines.vh */
/*
  Register offsets, field positions and reset values of the two-port GPIO block.
  Assumes inclusion by bare name from the design files.
*/
`ifndef GPDE_DEFINES_VH
`define GPDE_DEFINES_VH
`define GPDE_OFS_D_DATA 8'h03
`define GPDE_OFS_E_DATA 8'h08
`define GPDE_OFS_D_DIR 8'h04
`define GPDE_OFS_E_DIR 8'h09
`define GPDE_OFS_OPTION2 8'h0C
`define GPDE_OFS_CTRL 8'h0D
`define GPDE_BYTE_ADDR(i) ({i, 2'b00})
`define GPDE_OPT_D2PD 0
`define GPDE_OPT_D3PD 1
`define GPDE_OPT_D7PD 2
`define GPDE_OPT_DPPULL 3
`define GPDE_OPT_E2P 4
`define GPDE_OPT_E3P 5
`define GPDE_OPT_RESET 8'h00
`define GPDE_OPT_MASK 8'h3F
`define GPDE_CTL_USB_BLOCK_ENABLE 0
`define GPDE_CTL_KBDEN 1
`define GPDE_CTL_E3IRQ 2
`define GPDE_CTL_SPIEN 3
`define GPDE_CTL_RESET 8'h00
`define GPDE_CTL_MASK 8'h0F
`define GPDE_DIR_RESET 8'h00
`define GPDE_E_MASK 8'hFC
`endif

/* src/gpde_sync.v */
/*
  Two-flip-flop synchroniser for a bus of pin levels.
  Assumes pins are asynchronous to hclk.
*/
`timescale 1ns/1ns
module gpde_sync #(
  parameter W = 8
) (
  input wire hclk,
  input wire hresetn,
  input wire [W-1:0] async_in,
  output reg [W-1:0] sync_out
);
  reg [W-1:0] meta_q;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= {W{1'b0}};
      sync_out <= {W{1'b0}};
    end else begin
      meta_q <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // gpde_sync

/* src/gpde_pin.v */
/*
  One GPIO pin cell: output enable from direction, read mux latch or pin.
  Assumes the pin level is already synchronised.
*/
`timescale 1ns/1ns
module gpde_pin (
  input wire dir,
  input wire latch,
  input wire pin_sync,
  output wire oe,
  output wire rd
);
  // Output buffer on when direction is one
  assign oe = dir;
  // Read returns latch for outputs, pin level for inputs
  assign rd = dir ? latch : pin_sync;
endmodule // gpde_pin

/* src/gpde_top.v */
/*
  Two GPIO ports (8-bit first port, 6-bit second port bits 7:2) with pin-function
  priority logic for USB, keyboard clock, external interrupt and SPI, behind an
  AHB-Lite slave. Assumes single-word AHB-Lite transfers and one clock hclk.
*/
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ns
`include "gpde_defines.vh"
module gpde_top (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  input wire [7:0] d_pin_in,
  output wire [7:0] d_pin_out,
  output wire [7:0] d_pin_oe,
  output wire [7:0] d_pullup_on,
  input wire [7:0] e_pin_in,
  output wire [7:0] e_pin_out,
  output wire [7:0] e_pin_oe,
  output wire e2_weak_pullup_on,
  output wire e3_weak_pullup_on,
  output wire e2_dplus_pullup_on,
  output wire usb_block_enable,
  output wire usb_dplus_in,
  output wire usb_dminus_in,
  input wire kbd_clock_out,
  output wire kbd_clock_in,
  output wire e3_irq_in,
  input wire [7:4] spi_out,
  input wire [7:4] spi_oe,
  output wire [7:4] spi_in
);
  reg [7:0] first_port_latch_q;
  reg [7:0] first_port_direction_q;
  reg [7:0] second_port_latch_q;
  reg [7:0] second_port_direction_q;
  reg [7:0] port_option_reg_two_q;
  reg [7:0] mux_ctrl_q;
  reg wr_pend_q;
  reg [7:0] wr_idx_q;
  wire [7:0] d_sync;
  wire [7:0] e_sync;
  wire [7:0] d_rd;
  wire [7:0] e_rd;
  wire [7:0] e_gpio_oe;
  wire [7:0] rd_idx;
  wire take;
  wire kbd_clock_gen_enable;
  wire pin_e3_irq_enable;
  wire serial_if_enable;
  wire dplus_pullup_enable;
  wire pin_e2_weak_pullup_enable;
  wire pin_e3_weak_pullup_enable;
  reg [7:0] rd_mux;
  wire wr_d_data;
  wire wr_e_data;
  wire wr_d_dir;
  wire wr_e_dir;
  wire wr_opt;
  wire wr_ctl;
  wire [7:0] wr_byte;
  wire rd_take;
  wire [7:0] d_lat_view;
  wire [7:0] e_lat_view;
  wire [7:0] d_dir_view;
  wire [7:0] e_dir_view;
  wire [7:0] opt_view;
  wire [7:0] ctl_view;
  wire [7:0] d_rd_view;
  wire [7:0] e_rd_view;
  reg [2:0] e2_func;
  reg e2_pull_low;
  reg [2:0] e3_func;
  reg e3_pull_low;

  // Always ready, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign take = hsel & hready & htrans[1];
  assign rd_idx = haddr[9:2];

  gpde_sync #(.W(8)) u_sync_d (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(d_pin_in),
    .sync_out(d_sync)
  );

  gpde_sync #(.W(8)) u_sync_e (
    .hclk(hclk),
    .hresetn(hresetn),
    .async_in(e_pin_in),
    .sync_out(e_sync)
  );

  assign usb_block_enable = mux_ctrl_q[`GPDE_CTL_USB_BLOCK_ENABLE];
  assign kbd_clock_gen_enable = mux_ctrl_q[`GPDE_CTL_KBDEN];
  assign pin_e3_irq_enable = mux_ctrl_q[`GPDE_CTL_E3IRQ];
  assign serial_if_enable = mux_ctrl_q[`GPDE_CTL_SPIEN];
  assign dplus_pullup_enable = port_option_reg_two_q[`GPDE_OPT_DPPULL];
  assign pin_e2_weak_pullup_enable = port_option_reg_two_q[`GPDE_OPT_E2P];
  assign pin_e3_weak_pullup_enable = port_option_reg_two_q[`GPDE_OPT_E3P];

  // Bus pipeline: remember a write from its address phase to its data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= 8'h00;
    end else begin
      wr_pend_q <= take & hwrite;
      wr_idx_q <= rd_idx;
    end
  end

  // Write strobes in the data phase, one per register
  assign wr_d_data = wr_pend_q & (wr_idx_q == `GPDE_OFS_D_DATA);
  assign wr_e_data = wr_pend_q & (wr_idx_q == `GPDE_OFS_E_DATA);
  assign wr_d_dir = wr_pend_q & (wr_idx_q == `GPDE_OFS_D_DIR);
  assign wr_e_dir = wr_pend_q & (wr_idx_q == `GPDE_OFS_E_DIR);
  assign wr_opt = wr_pend_q & (wr_idx_q == `GPDE_OFS_OPTION2);
  assign wr_ctl = wr_pend_q & (wr_idx_q == `GPDE_OFS_CTRL);
  assign wr_byte = hwdata[7:0];

  // Latches are not reset
  always @(posedge hclk) begin
    if (wr_d_data) begin
      first_port_latch_q <= wr_byte;
    end
  end

  always @(posedge hclk) begin
    if (wr_e_data) begin
      second_port_latch_q <= wr_byte & `GPDE_E_MASK;
    end
  end

  // First-port direction, cleared to inputs
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first_port_direction_q <= `GPDE_DIR_RESET;
    end else if (wr_d_dir) begin
      first_port_direction_q <= wr_byte;
    end
  end

  // Second-port direction, bits 1:0 never set
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      second_port_direction_q <= `GPDE_DIR_RESET;
    end else if (wr_e_dir) begin
      second_port_direction_q <= wr_byte & `GPDE_E_MASK;
    end
  end

  // Pullup options, first-port pullups on and second-port pullups off after reset
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      port_option_reg_two_q <= `GPDE_OPT_RESET;
    end else if (wr_opt) begin
      port_option_reg_two_q <= wr_byte & `GPDE_OPT_MASK;
    end
  end

  // Pin-function control, all functions off after reset
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mux_ctrl_q <= `GPDE_CTL_RESET;
    end else if (wr_ctl) begin
      mux_ctrl_q <= wr_byte & `GPDE_CTL_MASK;
    end
  end

  // Per-pin read mux and output enables
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_pin
      gpde_pin u_d (
        .dir(first_port_direction_q[g]),
        .latch(first_port_latch_q[g]),
        .pin_sync(d_sync[g]),
        .oe(d_pin_oe[g]),
        .rd(d_rd[g])
      );
      gpde_pin u_e (
        .dir(second_port_direction_q[g]),
        .latch(second_port_latch_q[g]),
        .pin_sync(e_sync[g]),
        .oe(e_gpio_oe[g]),
        .rd(e_rd[g])
      );
    end
  endgenerate

  assign d_pin_out = first_port_latch_q;
  // Pullups on pins 2, 3, 7 unless disabled; other pins have none
  assign d_pullup_on[0] = 1'b0;
  assign d_pullup_on[1] = 1'b0;
  assign d_pullup_on[2] = ~port_option_reg_two_q[`GPDE_OPT_D2PD];
  assign d_pullup_on[3] = ~port_option_reg_two_q[`GPDE_OPT_D3PD];
  assign d_pullup_on[4] = 1'b0;
  assign d_pullup_on[5] = 1'b0;
  assign d_pullup_on[6] = 1'b0;
  assign d_pullup_on[7] = ~port_option_reg_two_q[`GPDE_OPT_D7PD];

  // E7..E4: SPI override, all four pins switched by one enable
  genvar s;
  generate
    for (s = 4; s < 8; s = s + 1) begin : g_spi
      assign e_pin_out[s] = serial_if_enable ? spi_out[s] : second_port_latch_q[s];
      assign e_pin_oe[s] = serial_if_enable ? spi_oe[s] : e_gpio_oe[s];
    end
  endgenerate
  assign spi_in = e_sync[7:4];

  // E2: USB > keyboard clock > GPIO, open-drain when not USB
  localparam [2:0] E2_USB = 3'b001;
  localparam [2:0] E2_KBD = 3'b010;
  localparam [2:0] E2_GPIO = 3'b100;
  always @* begin
    if (usb_block_enable) begin
      e2_func = E2_USB;
    end else if (kbd_clock_gen_enable) begin
      e2_func = E2_KBD;
    end else begin
      e2_func = E2_GPIO;
    end
  end
  // Open-drain: only ever pull the pin low
  always @* begin
    case (e2_func)
      E2_USB: e2_pull_low = 1'b0;
      E2_KBD: e2_pull_low = ~kbd_clock_out;
      E2_GPIO: e2_pull_low = e_gpio_oe[2] & ~second_port_latch_q[2];
      default: e2_pull_low = 1'b0;
    endcase
  end
  assign e_pin_out[2] = 1'b0;
  assign e_pin_oe[2] = e2_pull_low;

  // E3: USB > interrupt input > GPIO
  localparam [2:0] E3_USB = 3'b001;
  localparam [2:0] E3_IRQ = 3'b010;
  localparam [2:0] E3_GPIO = 3'b100;
  always @* begin
    if (usb_block_enable) begin
      e3_func = E3_USB;
    end else if (pin_e3_irq_enable) begin
      e3_func = E3_IRQ;
    end else begin
      e3_func = E3_GPIO;
    end
  end
  // Interrupt input ignores the direction bit
  always @* begin
    case (e3_func)
      E3_USB: e3_pull_low = 1'b0;
      E3_IRQ: e3_pull_low = 1'b0;
      E3_GPIO: e3_pull_low = e_gpio_oe[3] & ~second_port_latch_q[3];
      default: e3_pull_low = 1'b0;
    endcase
  end
  assign e_pin_out[3] = 1'b0;
  assign e_pin_oe[3] = e3_pull_low;
  assign e_pin_out[1:0] = 2'b00;
  assign e_pin_oe[1:0] = 2'b00;

  assign e2_dplus_pullup_on = dplus_pullup_enable;
  assign e2_weak_pullup_on = ~usb_block_enable & pin_e2_weak_pullup_enable &
    ~dplus_pullup_enable;
  assign e3_weak_pullup_on = ~usb_block_enable & pin_e3_weak_pullup_enable;

  assign usb_dplus_in = usb_block_enable & e_sync[2];
  assign usb_dminus_in = usb_block_enable & e_sync[3];
  assign kbd_clock_in = e_sync[2];
  assign e3_irq_in = ~usb_block_enable & pin_e3_irq_enable & e_sync[3];

  // Bypass a write still in its data phase, so a read right behind it sees the new value
  assign d_lat_view = wr_d_data ? wr_byte : first_port_latch_q;
  assign e_lat_view = wr_e_data ? (wr_byte & `GPDE_E_MASK) : second_port_latch_q;
  assign d_dir_view = wr_d_dir ? wr_byte : first_port_direction_q;
  assign e_dir_view = wr_e_dir ? (wr_byte & `GPDE_E_MASK) : second_port_direction_q;
  assign opt_view = wr_opt ? (wr_byte & `GPDE_OPT_MASK) : port_option_reg_two_q;
  assign ctl_view = wr_ctl ? (wr_byte & `GPDE_CTL_MASK) : mux_ctrl_q;
  assign d_rd_view = (wr_d_data | wr_d_dir) ?
    ((d_dir_view & d_lat_view) | (~d_dir_view & d_sync)) : d_rd;
  assign e_rd_view = (wr_e_data | wr_e_dir) ?
    ((e_dir_view & e_lat_view) | (~e_dir_view & e_sync)) : e_rd;
  assign rd_take = take & ~hwrite;

  always @* begin
    case (rd_idx)
      `GPDE_OFS_D_DATA: rd_mux = d_rd_view;
      `GPDE_OFS_E_DATA: rd_mux = e_rd_view & `GPDE_E_MASK;
      `GPDE_OFS_D_DIR: rd_mux = d_dir_view;
      `GPDE_OFS_E_DIR: rd_mux = e_dir_view;
      `GPDE_OFS_OPTION2: rd_mux = opt_view;
      `GPDE_OFS_CTRL: rd_mux = ctl_view;
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data registered for the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (rd_take) begin
      hrdata <= {24'h000000, rd_mux};
    end
  end
endmodule // gpde_top

/* bench/gpde_checker.sv */
/*
  Port assertions for the two-port GPIO block.
  Assumes it is bound onto gpde_top, one clock hclk.
*/
`timescale 1ns/1ns
module gpde_checker (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hwdata,
  input wire hreadyout,
  input wire hresp,
  input wire [7:0] d_pin_oe,
  input wire [7:0] d_pullup_on,
  input wire [7:0] e_pin_in,
  input wire [7:0] e_pin_out,
  input wire [7:0] e_pin_oe,
  input wire e2_weak_pullup_on,
  input wire e3_weak_pullup_on,
  input wire e2_dplus_pullup_on,
  input wire usb_block_enable,
  input wire e3_irq_in,
  input wire [7:4] spi_in
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_ddir_wr;
    hsel && hready && htrans[1] && hwrite && haddr == 32'h10;
  endsequence
  AST_BUS: assert property (hreadyout && !hresp) else $error("bus stall");
  AST_RST: assert property ($rose(hresetn) |-> (d_pin_oe | e_pin_oe) == 8'h00)
    else $error("pin driven after reset");
  AST_DWR: assert property (s_ddir_wr ##1 1 |=> {24'h0, d_pin_oe} == $past(hwdata))
    else $error("direction write lost");
  AST_OD: assert property ({e_pin_out[3:2], e_pin_oe[1:0]} == 4'h0)
    else $error("open-drain pin driven high");
  AST_WEAK: assert property (usb_block_enable |-> !e2_weak_pullup_on && !e3_weak_pullup_on)
    else $error("weak pullup with usb");
  AST_PRIO: assert property (e2_dplus_pullup_on |-> !e2_weak_pullup_on)
    else $error("both pullups on");
  AST_IRQ: assert property (usb_block_enable |-> !e3_irq_in) else $error("irq with usb");
  AST_SYNC: assert property ($past(hresetn, 2) && $past(hresetn) |->
    {spi_in, 4'h0} == ($past(e_pin_in, 2) & 8'hF0)) else $error("sync lag wrong");
  AST_DPULL: assert property ({d_pullup_on[6:4], d_pullup_on[1:0]} == 5'h00)
    else $error("pullup on wrong pin");
endmodule // gpde_checker
bind gpde_top gpde_checker u_checker (.*);

/* bench/gpde_board.sv */
/*
  Board model: resolves pin levels from the block's drive and the board's own levels.
  Assumes a driven pin wins over the board.
*/
`timescale 1ns/1ns
module gpde_board (
  input wire logic [7:0] d_pin_out,
  input wire logic [7:0] d_pin_oe,
  input wire logic [7:0] e_pin_out,
  input wire logic [7:0] e_pin_oe,
  input wire logic [7:0] ext_d,
  input wire logic [7:0] ext_e,
  output logic [7:0] d_pin_in,
  output logic [7:0] e_pin_in
);
  assign d_pin_in = (d_pin_oe & d_pin_out) | (~d_pin_oe & ext_d);
  assign e_pin_in = (e_pin_oe & e_pin_out) | (~e_pin_oe & ext_e);
endmodule // gpde_board

/* bench/gpde_top_bench.sv */
/*
  Self-checking bench for the GPIO block.
  Assumes the board model and checker beside it.
*/
`timescale 1ns/1ns
module gpde_top_bench;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0] d_pin_in, d_pin_out, d_pin_oe, d_pullup_on, e_pin_in, e_pin_out, e_pin_oe;
  logic [7:0] ext_d, ext_e, rd, dl, dd, el, ed, xd, xe, c, o;
  logic e2_weak_pullup_on, e3_weak_pullup_on, e2_dplus_pullup_on, usb_block_enable;
  logic usb_dplus_in, usb_dminus_in, kbd_clock_out, kbd_clock_in, e3_irq_in;
  logic [7:4] spi_out, spi_oe, spi_in;
  int n_mismatch, comparisons;
  gpde_top DUT (.*);
  gpde_board u_board (.*);
  task bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd, output logic [7:0] q);
    hsel <= 1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {22'h0, idx, 2'b00};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 0;
    hwdata <= {24'h0, wd};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata[7:0];
  endtask
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task complete_run;
    $display("comparisons=%0d n_mismatch=%0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  function automatic logic [7:0] rd_exp(input logic [7:0] dir, lat, pin);
    return (dir & lat) | (~dir & pin);
  endfunction
  function automatic logic [7:0] e_oe(input logic [7:0] m, dir, lat, input logic [3:0] so,
    input logic kc);
    e_oe = dir & 8'hF0;
    if (m[3]) e_oe[7:4] = so;
    e_oe[3] = !m[0] && !m[2] && dir[3] && !lat[3];
    e_oe[2] = !m[0] && (m[1] ? !kc : dir[2] && !lat[2]);
  endfunction
  initial begin
    hclk = 0;
    forever #2 hclk = ~hclk;
  end
  initial begin
    #20000;
    n_mismatch++;
    complete_run;
  end
  initial begin
    {hresetn, hsel, hwrite, htrans, haddr, hwdata, ext_d, ext_e} = 0;
    {kbd_clock_out, spi_out, spi_oe} = 0;
    hready = 1;
    hsize = 3'h2;
    n_mismatch = 0;
    comparisons = 0;
    void'($urandom(11));
    repeat (10) @(posedge hclk);
    hresetn <= 1;
    chk(d_pullup_on, 8'h8C);
    foreach (dl[i]) if (i > 3) begin
      bus(0, 8'h04 + (i & 1) * 5 + (i > 5) * 8, 0, rd);
      chk(rd, 8'h00);
    end
    repeat (20) begin
      {dl, dd, el, ed} = $urandom;
      {xd, xe} = $urandom;
      bus(1, 8'h03, dl, rd);
      bus(1, 8'h04, dd, rd);
      bus(1, 8'h08, el, rd);
      bus(1, 8'h09, ed, rd);
      ext_d <= xd;
      ext_e <= xe;
      repeat (3) @(posedge hclk);
      chk(d_pin_oe, dd);
      chk(d_pin_out, dl);
      chk(e_pin_oe, e_oe(8'h00, ed, el, 4'h0, 1'b0));
      bus(0, 8'h03, 0, rd);
      chk(rd, rd_exp(dd, dl, xd));
      bus(0, 8'h08, 0, rd);
      chk(rd, rd_exp(ed, el, xe) & 8'hFC);
    end
    for (c = 0; c < 16; c++) begin
      {o, xd, xe} = $urandom;
      bus(1, 8'h0C, o & 8'h3F, rd);
      bus(1, 8'h0D, c, rd);
      bus(0, 8'h0D, 0, rd);
      chk(rd, c);
      kbd_clock_out <= xd[0];
      spi_out <= xd[7:4];
      spi_oe <= xe[7:4];
      ext_e <= xe;
      repeat (3) @(posedge hclk);
      chk(e_pin_oe, e_oe(c, ed, el, xe[7:4], xd[0]));
      chk(e_pin_out, {c[3] ? xd[7:4] : el[7:4], 4'h0});
      chk(d_pullup_on, {!o[2], 3'h0, !o[1], !o[0], 2'h0});
      chk({3'h0, !c[0] & c[2] & xe[3], !c[0] & o[4] & !o[3], !c[0] & o[5], o[3], c[0]},
        {3'h0, e3_irq_in, e2_weak_pullup_on, e3_weak_pullup_on, e2_dplus_pullup_on,
        usb_block_enable});
      bus(0, 8'h08, 0, rd);
      chk(rd, rd_exp(ed, el, e_pin_in) & 8'hFC);
    end
    complete_run;
  end
endmodule // gpde_top_bench
